// *** common/hap_cfg.svh ***
// constants for the host access port
// assumes a 100 MHz system clock
// Overview of operation
// - interrupt pin pulled low while any enabled pending indication stays set
// - port answers only while device select is held low
// - each falling edge of device select starts one serial frame, or any number of parallel reads then at most one write
// - parallel mode decodes eight address inputs to pick the register
// - eight two-way data lines carry write data in and read data out
// - bus style select low: strobe plus direction; high: separate strobes
// - serial mode ignores bus style select
// - direction input high means read, low means write
// - shared strobe is active low and qualifies the access
// - separate style: write strobe low writes the data lines
// - separate style: read strobe low drives register contents out
// - serial read data leaves on data line zero
// - serial input sampled on rising serial clock edges
// - serial output changes on falling serial clock edges
// - serial host select low: parallel mode; high: serial mode
// - reset pulse over 100 ns; registers reachable 2 ms afterwards
`ifndef HAP_CFG_SVH
`define HAP_CFG_SVH
`define HAP_CLK_MHZ 100
`define HAP_RESET_MIN_NS 100
`define HAP_READY_MS 2
`define HAP_READY_CYCLES (`HAP_READY_MS * 1000 * `HAP_CLK_MHZ)
`define HAP_RESET_MIN_CYCLES ((`HAP_RESET_MIN_NS * `HAP_CLK_MHZ + 999) / 1000)
`define HAP_SER_BITS 17
`define HAP_SER_DATA_POS 9
`define HAP_TEST_CLEAR 1'b0
`endif

// *** common/hap_pkg.sv ***
// types for the host access port
// used by the port top and its register store
package hap_pkg;
    typedef logic [7:0] hap_byte_t;
    typedef enum logic [1:0]
    {
        HAP_IDLE = 2'b00,
        HAP_PAR = 2'b01,
        HAP_SER = 2'b10,
        HAP_DONE = 2'b11
    } hap_state_t;
endpackage

// *** common/hap_reg_if.sv ***
// register store access bundle
// one clock, write and read in the same cycle allowed
interface hap_reg_if;
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport master (output wr_en, output addr, output wdata, input rdata);
    modport store (input wr_en, input addr, input wdata, output rdata);
endinterface

// *** hw/hap_regs.sv ***
// 256 x 8 register store for the host access port
// read data registered, one cycle after the address
module hap_regs
(
    input wire logic clk_sys,
    hap_reg_if.store bus
);
    import hap_pkg::*;
    hap_byte_t mem [256];
    hap_byte_t rd_q;

    always_ff @(posedge clk_sys)
    begin
        if (bus.wr_en)
            mem[bus.addr] <= bus.wdata;
        rd_q <= mem[bus.addr];
    end
    assign bus.rdata = rd_q;
endmodule // hap_regs

// *** hw/hap_port.sv ***
// host access port: parallel (two styles) and serial register access
// assumes external pins are asynchronous; irq sources come from core logic
`include "hap_cfg.svh"
module hap_port
#(
    parameter int unsigned READY_CYCLES = `HAP_READY_CYCLES
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic dev_sel_n,
    input wire logic serial_host_select,
    input wire logic bus_style_select,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic [7:0] data_oe,
    input wire logic rw_wr_sdi,
    input wire logic shared_strobe_n,
    input wire logic [7:0] irq_pending,
    input wire logic [7:0] irq_enable,
    output logic irq_out,
    output logic irq_oe,
    output logic test_mode,
    output logic port_ready
);
    import hap_pkg::*;

    logic rst_m_q, rst_q;
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rst_m_q <= 1'b0;
            rst_q <= 1'b0;
        end
        else
        begin
            rst_m_q <= 1'b1;
            rst_q <= rst_m_q;
        end
    end

    // two-flop synchronisers, first stage read only by second
    localparam int SW = 21;
    logic [SW-1:0] s1_q, s2_q, sync_in;
    assign sync_in = {dev_sel_n, serial_host_select, bus_style_select, addr_in,
                      data_in, rw_wr_sdi, shared_strobe_n};
    always_ff @(posedge clk_sys or negedge rst_q)
    begin
        if (!rst_q)
        begin
            s1_q <= '1;
            s2_q <= '1;
        end
        else
        begin
            s1_q <= sync_in;
            s2_q <= s1_q;
        end
    end
    logic cs_n, ser_mode, style, rw, strb, rw_prev_q, strb_prev_q, cs_prev_q;
    hap_byte_t a_s, d_s;
    assign cs_n = s2_q[20];
    assign ser_mode = s2_q[19];
    assign style = s2_q[18];
    assign a_s = s2_q[17:10];
    assign d_s = s2_q[9:2];
    assign rw = s2_q[1];
    assign strb = s2_q[0];

    hap_reg_if rif();
    hap_regs u_regs (.clk_sys(clk_sys), .bus(rif));

    hap_state_t st_q, st_d;
    logic [16:0] sh_q, sh_d;
    logic [4:0] cnt_q, cnt_d;
    hap_byte_t rdat_q, rdat_d, dout_q, dout_d, doe_q, doe_d;
    logic wr_d, wr_q;
    logic srd_q, srd_d;
    hap_byte_t wa_d, wa_q, wd_d, wd_q;
    logic test_q, test_d, irq_q, irq_d;
    logic [31:0] rdy_cnt_q, rdy_cnt_d;
    logic rdy_q, rdy_d;
    logic sclk_rise, sclk_fall, cs_fall, rd_act, wr_act, acc_act;

    assign cs_fall = cs_prev_q & ~cs_n;
    assign sclk_rise = strb & ~strb_prev_q;
    assign sclk_fall = ~strb & strb_prev_q;
    // style low: strobe qualifies direction; high: separate strobes
    assign rd_act = style ? ~strb : (~strb & rw);
    assign wr_act = style ? (~rw & strb & rw_prev_q) : (~strb & ~rw & strb_prev_q);
    assign acc_act = style ? (~rw & rw_prev_q) : (~strb & strb_prev_q);

    assign rif.addr = (st_q == HAP_SER) ? sh_q[7:0] : (wr_q ? wa_q : a_s);
    assign rif.wr_en = wr_q;
    assign rif.wdata = wd_q;

    always_comb
    begin
        st_d = st_q;
        sh_d = sh_q;
        cnt_d = cnt_q;
        rdat_d = rdat_q;
        dout_d = dout_q;
        doe_d = 8'h00;
        wr_d = 1'b0;
        wa_d = wa_q;
        wd_d = wd_q;
        srd_d = srd_q;
        test_d = test_q;
        rdy_cnt_d = rdy_cnt_q;
        rdy_d = rdy_q;
        if (!rdy_q)
        begin
            // registers unreachable until ready delay elapses
            if (rdy_cnt_q >= READY_CYCLES - 1)
                rdy_d = 1'b1;
            else
                rdy_cnt_d = rdy_cnt_q + 32'h1;
        end
        if (cs_n)
            test_d = `HAP_TEST_CLEAR;
        irq_d = |(irq_pending & irq_enable);
        case (st_q)
            HAP_IDLE:
            begin
                if (cs_fall && rdy_q)
                begin
                    cnt_d = 5'h00;
                    sh_d = '0;
                    srd_d = 1'b0;
                    st_d = ser_mode ? HAP_SER : HAP_PAR;
                end
            end
            HAP_PAR:
            begin
                if (cs_n)
                    st_d = HAP_IDLE;
                else if (rd_act)
                begin
                    dout_d = rif.rdata;
                    doe_d = 8'hff;
                end
                else if (wr_act)
                begin
                    wr_d = 1'b1;
                    wa_d = a_s;
                    wd_d = d_s;
                    st_d = HAP_DONE; // one write per select
                end
                else if (acc_act)
                    st_d = HAP_PAR;
            end
            HAP_SER:
            begin
                // rw bit moves on in the shifter, so the frame kind is held apart
                doe_d = {7'h00, srd_q && (cnt_q >= 5'(`HAP_SER_DATA_POS))};
                if (cs_n)
                    st_d = HAP_IDLE;
                else
                begin
                    if (sclk_rise)
                    begin
                        // rw bit, address byte, data byte, msb first
                        sh_d = {sh_q[15:0], rw};
                        cnt_d = cnt_q + 5'h1;
                        if (cnt_q == 5'h00)
                            srd_d = rw;
                        if (cnt_q == 5'(`HAP_SER_BITS - 1) && !sh_q[15])
                        begin
                            wr_d = 1'b1;
                            wa_d = sh_q[14:7];
                            wd_d = {sh_q[6:0], rw};
                            st_d = HAP_DONE;
                        end
                    end
                    if (sclk_fall && srd_q && cnt_q >= 5'(`HAP_SER_DATA_POS))
                    begin
                        // first data fall takes the byte straight from the store
                        if (cnt_q == 5'(`HAP_SER_DATA_POS))
                        begin
                            dout_d = {7'h00, rif.rdata[7]};
                            rdat_d = {rif.rdata[6:0], 1'b0};
                        end
                        else
                        begin
                            dout_d = {7'h00, rdat_q[7]};
                            rdat_d = {rdat_q[6:0], 1'b0};
                        end
                    end
                end
            end
            HAP_DONE:
            begin
                if (cs_n)
                    st_d = HAP_IDLE;
            end
            default: st_d = HAP_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_q)
    begin
        if (!rst_q)
        begin
            st_q <= HAP_IDLE;
            sh_q <= '0;
            cnt_q <= 5'h00;
            rdat_q <= 8'h00;
            dout_q <= 8'h00;
            doe_q <= 8'h00;
            wr_q <= 1'b0;
            wa_q <= 8'h00;
            wd_q <= 8'h00;
            srd_q <= 1'b0;
            test_q <= 1'b1;
            irq_q <= 1'b0;
            rdy_cnt_q <= 32'h0;
            rdy_q <= 1'b0;
            cs_prev_q <= 1'b1;
            rw_prev_q <= 1'b1;
            strb_prev_q <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
            sh_q <= sh_d;
            cnt_q <= cnt_d;
            rdat_q <= rdat_d;
            dout_q <= dout_d;
            doe_q <= doe_d;
            wr_q <= wr_d;
            wa_q <= wa_d;
            wd_q <= wd_d;
            srd_q <= srd_d;
            test_q <= test_d;
            irq_q <= irq_d;
            rdy_cnt_q <= rdy_cnt_d;
            rdy_q <= rdy_d;
            cs_prev_q <= cs_n;
            rw_prev_q <= rw;
            strb_prev_q <= strb;
        end
    end

    assign data_out = dout_q;
    assign data_oe = doe_q;
    assign irq_out = 1'b0 & irq_q;
    assign irq_oe = irq_q; // open drain: only ever pulls low
    assign test_mode = test_q;
    assign port_ready = rdy_q;
endmodule // hap_port

// *** tb/hap_port_properties.sv ***
// pin-level checks for the host access port
// bound into hap_port; one clock domain, async active-low reset
module hap_port_properties
#(
    parameter int unsigned READY_CYCLES = 20
)
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic dev_sel_n,
    input wire logic serial_host_select,
    input wire logic bus_style_select,
    input wire logic rw_wr_sdi,
    input wire logic shared_strobe_n,
    input wire logic [7:0] irq_pending,
    input wire logic [7:0] irq_enable,
    input wire logic [7:0] data_out,
    input wire logic [7:0] data_oe,
    input wire logic irq_out,
    input wire logic irq_oe,
    input wire logic test_mode,
    input wire logic port_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    int unsigned up_q;
    logic irq_any;
    assign irq_any = |(irq_pending & irq_enable);
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            up_q <= 0;
        else if (up_q < 32'hffff)
            up_q <= up_q + 1;
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence s_par_read;
        (!serial_host_select && !dev_sel_n && !shared_strobe_n && rw_wr_sdi && port_ready)[*7];
    endsequence
    sequence s_par_write;
        (!serial_host_select && !bus_style_select && !rw_wr_sdi)[*6];
    endsequence
    sequence s_sclk_high;
        (serial_host_select && !dev_sel_n && shared_strobe_n)[*6];
    endsequence
    a_irq_pull_low: assert property (irq_any [*4] |-> irq_oe)
        else $error("irq pin not pulled low");
    a_irq_release: assert property (!irq_any [*4] |-> !irq_oe)
        else $error("irq pin held low");
    a_irq_open_drain: assert property (irq_out == 1'b0)
        else $error("irq pin driven high");
    a_read_drives_bus: assert property (s_par_read |-> data_oe == 8'hff)
        else $error("read data not driven");
    a_idle_bus_released: assert property (dev_sel_n [*6] |-> data_oe == 8'h00)
        else $error("bus driven while deselected");
    a_write_no_drive: assert property (s_par_write |-> data_oe == 8'h00)
        else $error("bus driven during write");
    a_serial_one_line: assert property (serial_host_select [*3] |-> data_oe[7:1] == 7'h00)
        else $error("upper data lines driven in serial mode");
    a_sdo_on_fall: assert property (s_sclk_high |=> $stable(data_out[0]))
        else $error("serial output moved while clock high");
    a_test_mode_clear: assert property (dev_sel_n [*8] |=> !test_mode)
        else $error("test mode not cleared");
    a_ready_wait: assert property ($rose(port_ready) |-> up_q >= READY_CYCLES)
        else $error("port ready too early");
    a_ready_late: assert property (up_q >= READY_CYCLES + 8 |-> port_ready)
        else $error("port ready too late");
endmodule // hap_port_properties

bind hap_port hap_port_properties #(.READY_CYCLES(READY_CYCLES)) i_props (.clk_sys, .reset_n,
    .dev_sel_n, .serial_host_select, .bus_style_select, .rw_wr_sdi, .shared_strobe_n,
    .irq_pending, .irq_enable, .data_out, .data_oe, .irq_out, .irq_oe, .test_mode, .port_ready);

// *** tb/hap_host.sv ***
// host processor model driving the port pins
// tasks are entered at a falling clock edge and return at one
module hap_host
(
    input wire logic clk_sys,
    input wire logic [7:0] data_out,
    input wire logic [7:0] data_oe,
    output logic dev_sel_n,
    output logic serial_host_select,
    output logic bus_style_select,
    output logic [7:0] addr_in,
    output logic [7:0] data_in,
    output logic rw_wr_sdi,
    output logic shared_strobe_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] drv_q = 8'h00;
    logic drv_en = 1'b0;
    logic [7:0] flt_q = 8'h5a;
    // released lines toggle so stale data never passes as read data
    always @(posedge clk_sys)
        flt_q <= ~flt_q;
    always_comb
        for (int i = 0; i < 8; i++)
            data_in[i] = data_oe[i] ? data_out[i] : (drv_en ? drv_q[i] : flt_q[i]);
    initial
    begin
        dev_sel_n = 1'b1;
        serial_host_select = 1'b0;
        bus_style_select = 1'b0;
        addr_in = 8'h00;
        rw_wr_sdi = 1'b1;
        shared_strobe_n = 1'b1;
    end
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic mode(input logic s);
        shared_strobe_n = !s;
        serial_host_select = s;
        wait_n(6);
    endtask
    task automatic par(input logic st, input logic rd, input logic [7:0] a,
        input logic [7:0] d, output logic [7:0] q);
        dev_sel_n = 1'b0;
        addr_in = a;
        bus_style_select = st;
        drv_q = d;
        drv_en = !rd;
        rw_wr_sdi = st ? 1'b1 : rd;
        wait_n(3);
        if (st && !rd)
            rw_wr_sdi = 1'b0;
        else
            shared_strobe_n = 1'b0;
        wait_n(8);
        q = data_in;
        rw_wr_sdi = 1'b1;
        shared_strobe_n = 1'b1;
        wait_n(4);
        dev_sel_n = 1'b1;
        drv_en = 1'b0;
        wait_n(4);
    endtask
    task automatic ser(input logic rd, input logic [7:0] a, input logic [7:0] d,
        output logic [7:0] q);
        logic [16:0] f;
        f = {rd, a, d};
        dev_sel_n = 1'b0;
        wait_n(4);
        for (int i = 16; i >= 0; i--)
        begin
            rw_wr_sdi = f[i];
            wait_n(8);
            if (i < 8)
                q[i] = data_in[0];
            shared_strobe_n = 1'b1;
            wait_n(8);
            shared_strobe_n = 1'b0;
        end
        wait_n(6);
        dev_sel_n = 1'b1;
        wait_n(4);
    endtask
endmodule // hap_host

// *** tb/hap_port_bench.sv ***
// self-checking bench for the host access port
// shadow memory predicts read data; serial clock period 160 ns
module hap_port_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import hap_pkg::*;
    logic clk_sys = 1'b0;
    logic reset_n = 1'b0;
    hap_byte_t irq_pending = 8'h00;
    hap_byte_t irq_enable = 8'h00;
    wire logic dev_sel_n, serial_host_select, bus_style_select, rw_wr_sdi, shared_strobe_n;
    wire logic [7:0] addr_in, data_in, data_out, data_oe;
    logic irq_out, irq_oe, test_mode, port_ready;
    logic [15:0] lfsr = 16'hc669;
    hap_byte_t mem [256];
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    hap_port #(.READY_CYCLES(20)) i_dut (.clk_sys, .reset_n, .dev_sel_n, .serial_host_select,
        .bus_style_select, .addr_in, .data_in, .data_out, .data_oe, .rw_wr_sdi,
        .shared_strobe_n, .irq_pending, .irq_enable, .irq_out, .irq_oe, .test_mode, .port_ready);
    hap_host i_host (.clk_sys, .data_out, .data_oe, .dev_sel_n, .serial_host_select,
        .bus_style_select, .addr_in, .data_in, .rw_wr_sdi, .shared_strobe_n);
    initial forever #5 clk_sys = ~clk_sys;
    function automatic logic [15:0] step(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [7:0] exp_irq(input hap_byte_t p, input hap_byte_t e);
        return {7'h00, |(p & e)};
    endfunction
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // hang guard, well above the longest expected run
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end
    initial
    begin
        hap_byte_t q, a, d;
        repeat (4) @(negedge clk_sys);
        chk({6'h00, test_mode, port_ready}, 8'h02);
        chk(data_oe, 8'h00);
        reset_n = 1'b1;
        repeat (6) @(negedge clk_sys);
        chk({7'h00, port_ready}, 8'h00);
        repeat (30) @(negedge clk_sys);
        chk({6'h00, test_mode, port_ready}, 8'h01);
        for (int k = 0; k < 48; k++)
        begin
            lfsr = step(lfsr);
            a = (k == 0) ? 8'h00 : (k == 1) ? 8'hff : lfsr[15:8];
            d = lfsr[7:0];
            lfsr = step(lfsr);
            irq_pending = lfsr[7:0];
            irq_enable = (k % 4 == 0) ? 8'h00 : lfsr[15:8];
            i_host.par(lfsr[3], 1'b0, a, d, q);
            mem[a] = d;
            chk({7'h00, irq_oe}, exp_irq(irq_pending, irq_enable));
            i_host.par(lfsr[9], 1'b1, a, 8'h00, q);
            chk(q, mem[a]);
        end
        i_host.mode(1'b1);
        i_host.ser(1'b0, 8'h3c, lfsr[7:0], q);
        mem[8'h3c] = lfsr[7:0];
        i_host.ser(1'b1, 8'h00, 8'h00, q);
        chk(q, mem[8'h00]);
        i_host.ser(1'b1, 8'hff, 8'h00, q);
        chk(q, mem[8'hff]);
        i_host.mode(1'b0);
        i_host.par(1'b1, 1'b1, 8'h3c, 8'h00, q);
        chk(q, mem[8'h3c]);
        report_and_stop();
    end
endmodule // hap_port_bench
